/* File: core/vic_pkg.sv */
// vic_pkg: register offsets, field layout and reset values of the vectored irq unit
package vic_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int VIC_SOURCES = 32;
  localparam int VIC_SLOTS = 16;
  localparam int VIC_ADDR_W = 12;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] VIC_OFF_NORMAL_STATUS = 12'h000;
  localparam logic [11:0] VIC_OFF_FAST_STATUS = 12'h004;
  localparam logic [11:0] VIC_OFF_RAW_STATUS = 12'h008;
  localparam logic [11:0] VIC_OFF_CLASS_SELECT = 12'h00c;
  localparam logic [11:0] VIC_OFF_ENABLE_MASK = 12'h010;
  localparam logic [11:0] VIC_OFF_ENABLE_CLEAR = 12'h014;
  localparam logic [11:0] VIC_OFF_SOFT_SET = 12'h018;
  localparam logic [11:0] VIC_OFF_SOFT_CLEAR = 12'h01c;
  localparam logic [11:0] VIC_OFF_ACTIVE_VECTOR = 12'h030;
  localparam logic [11:0] VIC_OFF_DEFAULT_VECTOR = 12'h034;
  localparam logic [11:0] VIC_OFF_EVENT_STATUS = 12'h040;
  localparam logic [11:0] VIC_OFF_EVENT_MASK = 12'h044;
  localparam logic [11:0] VIC_OFF_SLOT_ADDR_BASE = 12'h100;
  localparam logic [11:0] VIC_OFF_SLOT_CNTL_BASE = 12'h200;

  // ----------------------------------------------------------------
  // slot control field layout
  // ----------------------------------------------------------------
  localparam int VIC_CNTL_SRC_LSB = 0;
  localparam int VIC_CNTL_SRC_W = 5;
  localparam int VIC_CNTL_EN_BIT = 5;

  // ----------------------------------------------------------------
  // event status bits
  // ----------------------------------------------------------------
  localparam int VIC_EV_NORMAL = 0;
  localparam int VIC_EV_FAST = 1;
  localparam int VIC_EV_SPURIOUS = 2;
  localparam int VIC_EV_W = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] VIC_RST_WORD = 32'h0000_0000;

endpackage : vic_pkg

/* File: core/vic_prio_pick.sv */
// vic_prio_pick: finds the lowest numbered enabled slot whose source is requesting
`timescale 1ns/1ps
module vic_prio_pick
  import vic_pkg::*;
#(
  parameter int SLOTS = VIC_SLOTS,
  parameter int SOURCES = VIC_SOURCES
)
(
  input wire logic [SOURCES-1:0] i_request,
  input wire logic [SLOTS*6-1:0] i_slot_cntl,
  output logic o_hit,
  output logic [3:0] o_slot
);

  // ----------------------------------------------------------------
  // per-slot match
  // ----------------------------------------------------------------
  logic [SLOTS-1:0] match;

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++)
    begin : g_match
      assign match[g] = i_slot_cntl[g*6+VIC_CNTL_EN_BIT]
        & i_request[i_slot_cntl[g*6 +: VIC_CNTL_SRC_W]];
    end
  endgenerate

  // ----------------------------------------------------------------
  // priority: scan from the top down so slot 0 wins last
  // ----------------------------------------------------------------
  always_comb
  begin
    o_hit = 1'b0;
    o_slot = 4'h0;
    for (int i = SLOTS - 1; i >= 0; i--)
    begin
      if (match[i])
      begin
        o_hit = 1'b1;
        o_slot = 4'(i);
      end
    end
  end

endmodule : vic_prio_pick

/* File: core/vic_unit.sv */
// vic_unit: vectored irq unit with fast/normal routing, vector slots and register port
//
// Behaviour
// RL1: peripheral flag clearing drops the raw, fast and normal status bits at once.
// RL2: writing the active vector address ends service in the priority logic.
// RL3: a one in enable clear drops that enable mask bit.
// RL4: a one in software interrupt clear drops that software set bit only.
// RL5: a clear write acts once; software writes zero before clearing again.
// RL6: uncleared watchdog source is silenced by enable clear before return.
// RL7: class select zero routes a source to the normal request.
// RL8: enable mask ones enable sources; 0x06c0 enables 6, 7, 9 and 10.
// RL9: slot control holds source index and enable; slot 0 is highest priority.
// RL10: active vector reads the serviced slot's vector address.
// RL11: unvectored normal requests give the default vector address.
// RL12: fast status shows every active fast-routed source.
// RL13: a vanished triggering request reads back the default vector address.
// RL14: normal and fast requests follow enabled pending sources of each class.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module vic_unit
  import vic_pkg::*;
#(
  parameter int SOURCES = VIC_SOURCES,
  parameter int SLOTS = VIC_SLOTS
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [SOURCES-1:0] i_source_flag,
  input wire logic [VIC_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [31:0] o_rdata,
  output logic o_normal_request,
  output logic o_fast_request,
  output logic o_event_irq
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [SOURCES-1:0] interrupt_class_select;
  logic [SOURCES-1:0] interrupt_enable_mask;
  logic [SOURCES-1:0] software_interrupt_set;
  logic [31:0] default_vector_address;
  logic [31:0] slot_vector_address [SLOTS];
  logic [SLOTS*6-1:0] slot_vector_control;
  logic [VIC_EV_W-1:0] event_status;
  logic [VIC_EV_W-1:0] event_mask;

  // service tracking: a stack of slots in service, one bit per slot
  logic [SLOTS-1:0] in_service;
  logic fast_q;
  logic normal_q;

  // ----------------------------------------------------------------
  // combinational views
  // ----------------------------------------------------------------
  logic [SOURCES-1:0] raw_interrupt_status;
  logic [SOURCES-1:0] fast_request_status;
  logic [SOURCES-1:0] normal_request_status;
  logic pick_hit;
  logic [3:0] pick_slot;
  logic [SLOTS-1:0] slot_mask_above;
  logic [SLOTS-1:0] in_service_or_higher;
  logic serving_block;
  logic vector_read;
  logic vector_write;
  logic [31:0] active_vector_address;
  logic [31:0] next_rdata;
  logic [SOURCES-1:0] normal_vectored_src;
  logic spurious;

  // flags follow the peripheral directly, so a cleared flag vanishes everywhere
  assign raw_interrupt_status = i_source_flag | software_interrupt_set; // see RL1
  assign fast_request_status = raw_interrupt_status & interrupt_enable_mask
    & interrupt_class_select; // see RL12
  assign normal_request_status = raw_interrupt_status & interrupt_enable_mask
    & ~interrupt_class_select; // see RL7

  // request pins are pure functions of the status views
  assign o_fast_request = |fast_request_status; // see RL14
  assign o_normal_request = |normal_request_status; // see RL14

  assign vector_read = i_read && (i_addr == VIC_OFF_ACTIVE_VECTOR);
  assign vector_write = i_write && (i_addr == VIC_OFF_ACTIVE_VECTOR);

  // ----------------------------------------------------------------
  // priority selection among vector slots
  // ----------------------------------------------------------------
  vic_prio_pick #(
    .SLOTS(SLOTS),
    .SOURCES(SOURCES)
  ) u_pick (
    .i_request(normal_request_status),
    .i_slot_cntl(slot_vector_control),
    .o_hit(pick_hit),
    .o_slot(pick_slot)
  );

  // a slot in service blocks itself and every lower priority slot
  always_comb
  begin
    in_service_or_higher = '0;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (i == 0)
        in_service_or_higher[i] = in_service[i];
      else
        in_service_or_higher[i] = in_service[i] | in_service_or_higher[i-1];
    end
  end

  assign slot_mask_above = in_service_or_higher;
  assign serving_block = pick_hit && slot_mask_above[pick_slot];

  // which normal sources are claimed by an enabled slot
  always_comb
  begin
    normal_vectored_src = '0;
    for (int i = 0; i < SLOTS; i++)
    begin
      if (slot_vector_control[i*6+VIC_CNTL_EN_BIT])
        normal_vectored_src[slot_vector_control[i*6 +: VIC_CNTL_SRC_W]] = 1'b1;
    end
  end

  // vectored hit wins, otherwise default; a vanished request also lands on default
  always_comb
  begin
    if (pick_hit && !serving_block)
      active_vector_address = slot_vector_address[pick_slot]; // see RL9, RL10
    else
      active_vector_address = default_vector_address; // see RL11, RL13
  end

  // no normal request pending when the vector is fetched counts as spurious
  assign spurious = vector_read && !(|normal_request_status); // see RL13

  // ----------------------------------------------------------------
  // service state: entered on vector fetch, left on vector write
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      in_service <= '0;
    else if (vector_write)
    begin
      // release the highest priority slot in service
      for (int i = SLOTS - 1; i >= 0; i--)
      begin
        if (in_service[i] && !(i > 0 && in_service_or_higher[i > 0 ? i - 1 : 0]))
          in_service[i] <= 1'b0; // see RL2
      end
    end
    else if (vector_read && pick_hit && !serving_block)
      in_service[pick_slot] <= 1'b1;
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      interrupt_class_select <= '0;
      default_vector_address <= VIC_RST_WORD;
      event_mask <= '0;
    end
    else if (i_write)
    begin
      case (i_addr)
        VIC_OFF_CLASS_SELECT: interrupt_class_select <= i_wdata[SOURCES-1:0]; // see RL7
        VIC_OFF_DEFAULT_VECTOR: default_vector_address <= i_wdata;
        VIC_OFF_EVENT_MASK: event_mask <= i_wdata[VIC_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // enable mask: set register ors ones in, clear register strips ones out
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      interrupt_enable_mask <= '0;
    else if (i_write && i_addr == VIC_OFF_ENABLE_MASK)
      interrupt_enable_mask <= interrupt_enable_mask | i_wdata[SOURCES-1:0]; // see RL8
    else if (i_write && i_addr == VIC_OFF_ENABLE_CLEAR)
      interrupt_enable_mask <= interrupt_enable_mask & ~i_wdata[SOURCES-1:0]; // see RL3, RL6
  end

  // software set/clear; a clear write is a single strobe, so it acts once
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      software_interrupt_set <= '0;
    else if (i_write && i_addr == VIC_OFF_SOFT_SET)
      software_interrupt_set <= software_interrupt_set | i_wdata[SOURCES-1:0];
    else if (i_write && i_addr == VIC_OFF_SOFT_CLEAR)
      software_interrupt_set <= software_interrupt_set & ~i_wdata[SOURCES-1:0]; // see RL4, RL5
  end

  // ----------------------------------------------------------------
  // vector slots, one generate entry each
  // ----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < SLOTS; s++)
    begin : g_slot
      always_ff @(posedge i_clk_sys)
      begin
        if (i_reset)
        begin
          slot_vector_address[s] <= VIC_RST_WORD;
          slot_vector_control[s*6 +: 6] <= 6'h00;
        end
        else if (i_write && i_addr == VIC_OFF_SLOT_ADDR_BASE + 12'(s * 4))
          slot_vector_address[s] <= i_wdata;
        else if (i_write && i_addr == VIC_OFF_SLOT_CNTL_BASE + 12'(s * 4))
          slot_vector_control[s*6 +: 6] <= i_wdata[5:0]; // see RL9
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // event status: rising requests and spurious fetches, cleared on read
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      fast_q <= 1'b0;
      normal_q <= 1'b0;
    end
    else
    begin
      fast_q <= o_fast_request;
      normal_q <= o_normal_request;
    end
  end

  // set wins over the read clear so a coincident event is kept
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      event_status <= '0;
    else
    begin
      event_status <= (i_read && i_addr == VIC_OFF_EVENT_STATUS) ? '0 : event_status;
      if (o_normal_request && !normal_q)
        event_status[VIC_EV_NORMAL] <= 1'b1;
      if (o_fast_request && !fast_q)
        event_status[VIC_EV_FAST] <= 1'b1;
      if (spurious)
        event_status[VIC_EV_SPURIOUS] <= 1'b1;
    end
  end

  assign o_event_irq = |(event_status & event_mask);

  // ----------------------------------------------------------------
  // read port: data valid one cycle after the strobe only
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (i_addr)
      VIC_OFF_NORMAL_STATUS: next_rdata = 32'(normal_request_status);
      VIC_OFF_FAST_STATUS: next_rdata = 32'(fast_request_status); // see RL12
      VIC_OFF_RAW_STATUS: next_rdata = 32'(raw_interrupt_status); // see RL1
      VIC_OFF_CLASS_SELECT: next_rdata = 32'(interrupt_class_select);
      VIC_OFF_ENABLE_MASK: next_rdata = 32'(interrupt_enable_mask);
      VIC_OFF_SOFT_SET: next_rdata = 32'(software_interrupt_set);
      VIC_OFF_ACTIVE_VECTOR: next_rdata = active_vector_address; // see RL10, RL11
      VIC_OFF_DEFAULT_VECTOR: next_rdata = default_vector_address;
      VIC_OFF_EVENT_STATUS: next_rdata = 32'(event_status);
      VIC_OFF_EVENT_MASK: next_rdata = 32'(event_mask);
      default:
      begin
        for (int i = 0; i < SLOTS; i++)
        begin
          if (i_addr == VIC_OFF_SLOT_ADDR_BASE + 12'(i * 4))
            next_rdata = slot_vector_address[i];
          if (i_addr == VIC_OFF_SLOT_CNTL_BASE + 12'(i * 4))
            next_rdata = {26'h0, slot_vector_control[i*6 +: 6]};
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_rdata <= 32'h0000_0000;
    else if (i_read)
      o_rdata <= next_rdata;
    else
      o_rdata <= 32'h0000_0000;
  end

endmodule : vic_unit

/* File: sim/vic_core_model.sv */
// vic_core_model: processor core that latches a request and fetches the vector later
`timescale 1ns/1ps
module vic_core_model
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_request,
  input wire logic [3:0] i_latency,
  output logic o_fetch
);
  logic armed;
  logic [3:0] wait_cnt;

  // the core commits on the request level and is then blind to it through its pipeline,
  // so the fetch may come after the request has gone away
  always_ff @(posedge i_clk_sys)
  begin
    o_fetch <= 1'b0;
    if (i_reset)
      armed <= 1'b0;
    else if (!armed)
    begin
      armed <= i_request;
      wait_cnt <= i_latency;
    end
    else if (wait_cnt == 4'h0)
    begin
      o_fetch <= 1'b1;
      armed <= 1'b0;
    end
    else
      wait_cnt <= wait_cnt - 4'h1;
  end
endmodule : vic_core_model

/* File: sim/vic_unit_properties.sv */
// vic_unit_properties: port-level checks of the vectored irq unit
`timescale 1ns/1ps
module vic_unit_properties
  import vic_pkg::*;
#(
  parameter int SOURCES = VIC_SOURCES,
  parameter int SLOTS = VIC_SLOTS
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [SOURCES-1:0] i_source_flag,
  input wire logic [VIC_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [31:0] o_rdata,
  input wire logic o_normal_request,
  input wire logic o_fast_request,
  input wire logic o_event_irq
);
  logic [31:0] en_sh, sel_sh, soft_sh, def_sh, a0_sh;
  logic [5:0] c0_sh;
  logic busy0;
  wire rd_act = i_read && i_addr == VIC_OFF_ACTIVE_VECTOR;
  wire rd_fast = i_read && i_addr == VIC_OFF_FAST_STATUS;
  wire rd_raw = i_read && i_addr == VIC_OFF_RAW_STATUS && i_source_flag == '0;
  wire en_wipe = i_write && i_addr == VIC_OFF_ENABLE_CLEAR && i_wdata == 32'hffff_ffff;
  wire soft_wipe = i_write && i_addr == VIC_OFF_SOFT_CLEAR && i_wdata == 32'hffff_ffff;
  wire [4:0] s0 = c0_sh[4:0];
  wire slot0_pend = c0_sh[5] && (i_source_flag[s0] || soft_sh[s0]) && en_sh[s0] && !sel_sh[s0];

  // ------------------------------------------------------------------
  // shadow of the steering registers, only slot 0 is followed to keep it small
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      {en_sh, sel_sh, soft_sh, def_sh, a0_sh} <= '0;
      c0_sh <= 6'h00;
      busy0 <= 1'b0;
    end
    else
    begin
      if (i_write)
        case (i_addr)
          VIC_OFF_CLASS_SELECT: sel_sh <= i_wdata;
          VIC_OFF_ENABLE_MASK: en_sh <= en_sh | i_wdata;
          VIC_OFF_ENABLE_CLEAR: en_sh <= en_sh & ~i_wdata;
          VIC_OFF_SOFT_SET: soft_sh <= soft_sh | i_wdata;
          VIC_OFF_SOFT_CLEAR: soft_sh <= soft_sh & ~i_wdata;
          VIC_OFF_DEFAULT_VECTOR: def_sh <= i_wdata;
          VIC_OFF_SLOT_ADDR_BASE: a0_sh <= i_wdata;
          VIC_OFF_SLOT_CNTL_BASE: c0_sh <= i_wdata[5:0];
          VIC_OFF_ACTIVE_VECTOR: busy0 <= 1'b0;
          default: ;
        endcase
      if (rd_act && slot0_pend)
        busy0 <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence soft_wipe_s; soft_wipe; endsequence
  sequence raw_quiet_s; rd_raw; endsequence

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  rdata_idle_a: assert property (!$past(i_read) |-> o_rdata == 32'h0)
    else $error("read data not zero outside its cycle");
  reset_quiet_a: assert property (disable iff (1'b0) i_reset |=> !o_normal_request &&
    !o_fast_request && !o_event_irq && o_rdata == 32'h0) else $error("outputs not quiet in reset");
  enclr_silence_a: assert property (en_wipe |=> !o_normal_request && !o_fast_request)
    else $error("request left after enable clear");
  fast_status_a: assert property ($past(rd_fast) |-> (o_rdata != 32'h0) == $past(o_fast_request))
    else $error("fast status and fast request disagree");
  soft_clear_a: assert property (soft_wipe_s ##2 raw_quiet_s |=> o_rdata == 32'h0)
    else $error("raw status not empty after soft clear");
  slot0_vector_a: assert property (rd_act && slot0_pend && !busy0 |=> o_rdata == $past(a0_sh))
    else $error("slot 0 vector not returned");
  busy_default_a: assert property (rd_act && busy0 |=> o_rdata == $past(def_sh))
    else $error("vector returned while slot 0 in service");
  spurious_default_a: assert property (rd_act && !o_normal_request |=> o_rdata == $past(def_sh))
    else $error("default vector not returned without request");
endmodule : vic_unit_properties

bind vic_unit vic_unit_properties #(.SOURCES(SOURCES), .SLOTS(SLOTS)) i_vic_unit_properties (
  .i_clk_sys, .i_reset, .i_source_flag, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
  .o_normal_request, .o_fast_request, .o_event_irq);

/* File: sim/vic_unit_tb.sv */
// vic_unit_tb: self-checking bench of the vectored irq unit with a core model
`timescale 1ns/1ps
module vic_unit_tb
  import vic_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [31:0] flags = 32'h0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [31:0] rdata, d, rf, re, rs;
  logic [31:0] v [3];
  logic nreq, freq, evirq, fetch;
  int failures = 0;
  int cmp_count = 0;
  int seed = 32'h021d;
  logic [11:0] offs [9] = '{VIC_OFF_NORMAL_STATUS, VIC_OFF_FAST_STATUS, VIC_OFF_RAW_STATUS,
    VIC_OFF_CLASS_SELECT, VIC_OFF_ENABLE_MASK, VIC_OFF_DEFAULT_VECTOR, VIC_OFF_EVENT_STATUS,
    VIC_OFF_EVENT_MASK, 12'h0fc};

  vic_unit i_vic_unit (.i_clk_sys, .i_reset, .i_source_flag(flags), .i_addr(addr),
    .i_wdata(wdata), .i_write(wr), .i_read(rd), .o_rdata(rdata), .o_normal_request(nreq),
    .o_fast_request(freq), .o_event_irq(evirq));
  vic_core_model i_vic_core_model (.i_clk_sys, .i_reset, .i_request(nreq), .i_latency(lat),
    .o_fetch(fetch));

  // free running system clock
  initial forever #20 i_clk_sys = ~i_clk_sys;

  // ------------------------------------------------------------------
  // bus cycles, comparisons and expectations
  // ------------------------------------------------------------------
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] dv);
    @(posedge i_clk_sys);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(posedge i_clk_sys);
    wr <= 1'b0;
    #1; // let the written register settle before any output is looked at
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] dv);
    @(posedge i_clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk_sys);
    rd <= 1'b0;
    #1 dv = rdata; // data stand only in this cycle
  endtask : rd_reg
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask : chk
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] g;
    rd_reg(a, g);
    chk(n, e, g);
  endtask : rd_chk
  task automatic set_flags(input logic [31:0] f);
    @(posedge i_clk_sys);
    flags <= f;
  endtask : set_flags
  // bounded wait for the core to fetch, a lost fetch counts as a mismatch
  task automatic wait_fetch;
    int n;
    for (n = 0; n < 40 && fetch !== 1'b1; n++)
      @(posedge i_clk_sys) #1;
    chk("fetch", 32'h1, {31'h0, fetch});
  endtask : wait_fetch
  function automatic logic [31:0] status(input logic [31:0] f, e, s, input logic fast);
    return f & e & (fast ? s : ~s);
  endfunction : status
  task automatic end_sim;
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  // watchdog, well beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (5000) @(posedge i_clk_sys);
    failures++;
    end_sim();
  end

  // main sequence: reset, vectoring, spurious fetch, clears, random routing
  initial
  begin
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    foreach (offs[k]) rd_chk(offs[k], 32'h0, "reset value");
    foreach (v[k]) v[k] = $random(seed);
    wr_reg(VIC_OFF_CLASS_SELECT, 32'h0);
    wr_reg(VIC_OFF_ENABLE_MASK, 32'h0000_06c0);
    wr_reg(VIC_OFF_DEFAULT_VECTOR, v[0]);
    wr_reg(VIC_OFF_SLOT_ADDR_BASE, v[1]);
    wr_reg(VIC_OFF_SLOT_ADDR_BASE + 12'h004, v[2]);
    wr_reg(VIC_OFF_SLOT_CNTL_BASE, 32'h0000_0026);
    wr_reg(VIC_OFF_SLOT_CNTL_BASE + 12'h004, 32'h0000_002a);
    rd_chk(VIC_OFF_ENABLE_MASK, 32'h0000_06c0, "enable");
    set_flags(32'h0000_0440);
    wait_fetch();
    chk("normal req", 32'h1, {31'h0, nreq});
    rd_chk(VIC_OFF_ACTIVE_VECTOR, v[1], "slot0 vector");
    rd_chk(VIC_OFF_ACTIVE_VECTOR, v[0], "in service");
    wr_reg(VIC_OFF_ACTIVE_VECTOR, 32'h0);
    rd_chk(VIC_OFF_ACTIVE_VECTOR, v[1], "after end");
    wr_reg(VIC_OFF_ACTIVE_VECTOR, 32'h0);
    set_flags(32'h0000_0400);
    rd_chk(VIC_OFF_RAW_STATUS, 32'h0000_0400, "raw");
    rd_chk(VIC_OFF_ACTIVE_VECTOR, v[2], "slot1 vector");
    wr_reg(VIC_OFF_ACTIVE_VECTOR, 32'h0);
    set_flags(32'h0000_0280);
    rd_chk(VIC_OFF_ACTIVE_VECTOR, v[0], "unvectored");
    wr_reg(VIC_OFF_ACTIVE_VECTOR, 32'h0);
    // slow core: the request vanishes before the fetch, event masked at first
    lat <= 4'h8;
    set_flags(32'h0000_0040);
    set_flags(32'h0);
    rd_chk(VIC_OFF_EVENT_STATUS, 32'h0000_0001, "event flush");
    wait_fetch();
    rd_chk(VIC_OFF_ACTIVE_VECTOR, v[0], "spurious");
    chk("masked event", 32'h0, {31'h0, evirq});
    wr_reg(VIC_OFF_EVENT_MASK, 32'h0000_0004);
    chk("event irq", 32'h1, {31'h0, evirq});
    rd_reg(VIC_OFF_EVENT_STATUS, d);
    chk("spurious event", 32'h4, d & 32'h4);
    chk("event cleared", 32'h0, {31'h0, evirq});
    // a source that cannot be cleared at its source is silenced at the unit
    set_flags(32'h0000_0040);
    wr_reg(VIC_OFF_ENABLE_CLEAR, 32'h0000_0040);
    wr_reg(VIC_OFF_ENABLE_CLEAR, 32'h0);
    chk("silenced req", 32'h0, {31'h0, nreq});
    rd_chk(VIC_OFF_ENABLE_MASK, 32'h0000_0680, "enable clr");
    set_flags(32'h0);
    wr_reg(VIC_OFF_SOFT_SET, 32'h0000_0005);
    wr_reg(VIC_OFF_SOFT_CLEAR, 32'h0000_0001);
    wr_reg(VIC_OFF_SOFT_CLEAR, 32'h0);
    rd_chk(VIC_OFF_RAW_STATUS, 32'h0000_0004, "soft clr");
    wr_reg(VIC_OFF_SOFT_SET, 32'h0000_0001);
    rd_chk(VIC_OFF_RAW_STATUS, 32'h0000_0005, "clear once");
    wr_reg(VIC_OFF_SOFT_CLEAR, 32'hffff_ffff);
    rd_chk(VIC_OFF_RAW_STATUS, 32'h0, "soft wipe");
    wr_reg(VIC_OFF_SOFT_CLEAR, 32'h0);
    // random routing, the first pass puts two sources on the fast request
    for (int i = 0; i < 16; i++)
    begin
      rf = (i == 0) ? 32'h0000_04c0 : $random(seed);
      re = (i == 0) ? 32'h0000_06c0 : $random(seed);
      rs = (i == 0) ? 32'h0000_0480 : $random(seed);
      wr_reg(VIC_OFF_ENABLE_CLEAR, 32'hffff_ffff);
      wr_reg(VIC_OFF_ENABLE_CLEAR, 32'h0);
      wr_reg(VIC_OFF_CLASS_SELECT, rs);
      wr_reg(VIC_OFF_ENABLE_MASK, re);
      set_flags(rf);
      rd_chk(VIC_OFF_FAST_STATUS, status(rf, re, rs, 1'b1), "fast status");
      rd_chk(VIC_OFF_NORMAL_STATUS, status(rf, re, rs, 1'b0), "normal status");
      chk("fast req", {31'h0, |status(rf, re, rs, 1'b1)}, {31'h0, freq});
      chk("normal req", {31'h0, |status(rf, re, rs, 1'b0)}, {31'h0, nreq});
    end
    end_sim();
  end
endmodule : vic_unit_tb
